// ### cbf_defines.svh
/*
  Offsets, field positions, reset values and timing figures of the
  breaker failure supervision block. Assumes word addressing on the
  plain register port.
*/
`ifndef CBF_DEFINES_SVH
`define CBF_DEFINES_SVH

// Register word addresses
`define CBF_ADDR_CTRL 6'h00
`define CBF_ADDR_SIG_MASK 6'h01
`define CBF_ADDR_RELAY_MASK 6'h02
`define CBF_ADDR_STATUS 6'h03
`define CBF_ADDR_GROUP_BASE 6'h08
// Group block: four words per setting group
`define CBF_GRP_PHASE_THR 2'h0
`define CBF_GRP_RES_THR 2'h1
`define CBF_GRP_RETRIP_DLY 2'h2
`define CBF_GRP_FAIL_DLY 2'h3

// Control word fields
`define CBF_CTRL_USE_CUR 0
`define CBF_CTRL_USE_RELAY 1
`define CBF_CTRL_USE_SIG 2
`define CBF_CTRL_AND 3
`define CBF_CTRL_RETRIP_EN 4
`define CBF_CTRL_RES_LSB 5
`define CBF_CTRL_OVR_LSB 8

// Reset values: current only, retrip on, residual off, override field normal
`define CBF_CTRL_RESET 32'h0000_0011
`define CBF_PHASE_THR_RESET 12'h014
`define CBF_RES_THR_RESET 16'h04b0
`define CBF_RETRIP_DLY_RESET 19'h00014
`define CBF_FAIL_DLY_RESET 19'h00028

// Hysteresis: release below 97 of 100 parts of threshold
`define CBF_REL_NUM 7'h61
`define CBF_REL_DEN 7'h64

// Timing: program cycle and delay step both 5 ms, clock 100 ns
`define CBF_CYCLE_NS 5000000
`define CBF_CLK_NS 100
`define CBF_CYCLE_CLKS (`CBF_CYCLE_NS / `CBF_CLK_NS)

`endif

// ### cbf_pkg.sv
/*
  Types of the breaker failure supervision block.
  Assumes cbf_defines.svh for all numeric constants.
*/
package cbf_pkg;

  // Reported condition
  typedef enum logic [2:0] {
    CBF_NORMAL, CBF_START, CBF_RETRIP, CBF_FAIL, CBF_BLOCKED
  } cbf_cond_t;

  // Residual current source
  typedef enum logic [1:0] {
    CBF_RES_OFF, CBF_RES_ONE, CBF_RES_TWO, CBF_RES_CALC
  } cbf_res_sel_t;

  // Fundamental magnitudes: phases in 0.01 In, residuals in 0.001 In
  typedef struct packed {
    logic [15:0] phase_a;
    logic [15:0] phase_b;
    logic [15:0] phase_c;
    logic [15:0] residual_input_one;
    logic [15:0] residual_input_two;
    logic [15:0] calculated_residual;
  } cbf_meas_t;

endpackage

// ### cbf_pickup.sv
/*
  One overcurrent pick-up element with fixed release hysteresis.
  Assumes a one-cycle evaluation strobe from the parent.
*/
`timescale 1ns/1ps
`include "cbf_defines.svh"

module cbf_pickup #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic tick,
  input wire logic enable,
  input wire logic [W-1:0] magnitude,
  input wire logic [W-1:0] threshold,
  output logic picked
);
  logic picked_reg;
  logic picked_next;
  logic [W+6:0] mag_scaled;
  logic [W+6:0] thr_scaled;

  // Scale both sides so the 97 % release needs no divider
  assign mag_scaled = (W+7)'(magnitude) * (W+7)'(`CBF_REL_DEN);
  assign thr_scaled = (W+7)'(threshold) * (W+7)'(`CBF_REL_NUM);

  // Pick up above threshold, release below 97 % or when disabled
  always_comb begin
    picked_next = picked_reg;
    if (tick) begin
      if (!enable) begin
        picked_next = 1'b0;
      end else if (magnitude > threshold) begin
        picked_next = 1'b1;
      end else if (mag_scaled < thr_scaled) begin
        picked_next = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      picked_reg <= 1'b0;
    end else begin
      picked_reg <= picked_next;
    end
  end

  assign picked = picked_reg;
endmodule // cbf_pickup

// ### cbf_supervisor.sv
/*
  Breaker failure supervision: pick-up from current, relay states and
  binary signals; redundant trip and breaker failure delay timers;
  register port for settings and status.
  Assumes all inputs synchronous to core_clk and a single clock.
*/
// Contract
// - Pick-up from current, relays, signals, combinations
// - Current mode evaluates phases and residual
// - Signal mode accepts any binary signal
// - Relay mode watches chosen relay state
// - Fundamental magnitudes; residual from three sources
// - Residual selector four choices, resets disabled
// - Signal set counts only in signal modes
// - Relay set counts only in relay modes
// - Mode selector combinations, resets current only
// - Override condition when stage forcing enabled
// - Pick-up on any phase or residual
// - Release below 97 percent of threshold
// - Phase threshold 0.01 steps, default 0.20
// - Residual threshold 0.001 steps, default 1.200
// - Group settings switch while running
// - Static selections ignore group change
// - Redundant trip output can be disabled
// - Breaker failure output trips upstream breaker
// - One pick-up starts both timers
// - Redundant trip after delay, default 0.100 s
// - Breaker failure after delay, default 0.200 s
// - Block at pick-up reports blocked, resets
`timescale 1ns/1ps
`include "cbf_defines.svh"

module cbf_supervisor #(
  parameter int NUM_SIG = 16,
  parameter int NUM_RELAY = 8,
  parameter int NUM_GROUPS = 4,
  parameter int DLY_W = 19,
  parameter int CYCLE_CLKS = `CBF_CYCLE_CLKS
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  input wire cbf_pkg::cbf_meas_t meas,
  input wire logic [NUM_SIG-1:0] binary_signals,
  input wire logic [NUM_RELAY-1:0] relay_states,
  input wire logic [$clog2(NUM_GROUPS)-1:0] active_group,
  input wire logic block_in,
  input wire logic stage_forcing_en,
  output logic start_out,
  output logic blocked_out,
  output logic redundant_trip_out,
  output logic breaker_failure_output,
  output cbf_pkg::cbf_cond_t condition
);
  import cbf_pkg::*;

  localparam int GW = $clog2(NUM_GROUPS);
  localparam int CW = $clog2(CYCLE_CLKS);

  // Static settings
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [NUM_SIG-1:0] sig_mask_reg;
  logic [NUM_SIG-1:0] sig_mask_next;
  logic [NUM_RELAY-1:0] relay_mask_reg;
  logic [NUM_RELAY-1:0] relay_mask_next;
  // Group-dependent settings, one row per setting group
  logic [11:0] phase_thr_reg [NUM_GROUPS];
  logic [11:0] phase_thr_next [NUM_GROUPS];
  logic [15:0] res_thr_reg [NUM_GROUPS];
  logic [15:0] res_thr_next [NUM_GROUPS];
  logic [DLY_W-1:0] rt_dly_reg [NUM_GROUPS];
  logic [DLY_W-1:0] rt_dly_next [NUM_GROUPS];
  logic [DLY_W-1:0] bf_dly_reg [NUM_GROUPS];
  logic [DLY_W-1:0] bf_dly_next [NUM_GROUPS];
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Evaluation state
  logic [CW-1:0] div_reg;
  logic [CW-1:0] div_next;
  logic tick_reg;
  logic tick_next;
  logic [DLY_W-1:0] rt_cnt_reg;
  logic [DLY_W-1:0] rt_cnt_next;
  logic [DLY_W-1:0] bf_cnt_reg;
  logic [DLY_W-1:0] bf_cnt_next;
  cbf_cond_t cond_reg;
  cbf_cond_t cond_next;
  cbf_cond_t shown_reg;
  cbf_cond_t shown_next;
  logic start_reg;
  logic start_next;
  logic blocked_reg;
  logic blocked_next;
  logic retrip_reg;
  logic retrip_next;
  logic fail_reg;
  logic fail_next;

  // Decoded settings and pick-up terms
  cbf_res_sel_t res_sel;
  cbf_cond_t override_cond;
  logic use_cur;
  logic use_relay;
  logic use_sig;
  logic and_mode;
  logic retrip_en;
  logic [15:0] res_mag;
  logic [15:0] phase_mag [3];
  logic [3:0] cur_picked;
  logic cur_pick;
  logic relay_pick;
  logic sig_pick;
  logic pickup;
  logic [GW-1:0] wgrp;
  logic grp_hit;

  // mode fields, current only at reset
  assign use_cur = ctrl_reg[`CBF_CTRL_USE_CUR];
  assign use_relay = ctrl_reg[`CBF_CTRL_USE_RELAY];
  assign use_sig = ctrl_reg[`CBF_CTRL_USE_SIG];
  assign and_mode = ctrl_reg[`CBF_CTRL_AND];
  assign retrip_en = ctrl_reg[`CBF_CTRL_RETRIP_EN];
  assign res_sel = cbf_res_sel_t'(ctrl_reg[`CBF_CTRL_RES_LSB +: 2]);
  assign override_cond = cbf_cond_t'(ctrl_reg[`CBF_CTRL_OVR_LSB +: 3]);
  assign wgrp = GW'((reg_addr - `CBF_ADDR_GROUP_BASE) >> 2);
  assign grp_hit = (reg_addr >= `CBF_ADDR_GROUP_BASE) &&
    (reg_addr < 6'(`CBF_ADDR_GROUP_BASE + 4 * NUM_GROUPS));

  // Register writes; static words are not part of any group
  always_comb begin
    ctrl_next = ctrl_reg;
    sig_mask_next = sig_mask_reg;
    relay_mask_next = relay_mask_reg;
    phase_thr_next = phase_thr_reg;
    res_thr_next = res_thr_reg;
    rt_dly_next = rt_dly_reg;
    bf_dly_next = bf_dly_reg;
    if (reg_we) begin
      if (reg_addr == `CBF_ADDR_CTRL) begin
        ctrl_next = reg_wdata & 32'h0000_077f;
      end
      if (reg_addr == `CBF_ADDR_SIG_MASK) begin
        sig_mask_next = reg_wdata[NUM_SIG-1:0];
      end
      if (reg_addr == `CBF_ADDR_RELAY_MASK) begin
        relay_mask_next = reg_wdata[NUM_RELAY-1:0];
      end
      if (grp_hit) begin
        unique case (reg_addr[1:0])
          `CBF_GRP_PHASE_THR: phase_thr_next[wgrp] = reg_wdata[11:0];
          `CBF_GRP_RES_THR: res_thr_next[wgrp] = reg_wdata[15:0];
          `CBF_GRP_RETRIP_DLY: rt_dly_next[wgrp] = reg_wdata[DLY_W-1:0];
          `CBF_GRP_FAIL_DLY: bf_dly_next[wgrp] = reg_wdata[DLY_W-1:0];
        endcase
      end
    end
  end

  // Read data stands in the cycle after the strobe only
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_re) begin
      if (reg_addr == `CBF_ADDR_CTRL) begin
        rdata_next = ctrl_reg;
      end else if (reg_addr == `CBF_ADDR_SIG_MASK) begin
        rdata_next = 32'(sig_mask_reg);
      end else if (reg_addr == `CBF_ADDR_RELAY_MASK) begin
        rdata_next = 32'(relay_mask_reg);
      end else if (reg_addr == `CBF_ADDR_STATUS) begin
        rdata_next = {22'h0, cur_picked, pickup, retrip_en, cond_reg, shown_reg != cond_reg};
      end else if (grp_hit) begin
        unique case (reg_addr[1:0])
          `CBF_GRP_PHASE_THR: rdata_next = 32'(phase_thr_reg[wgrp]);
          `CBF_GRP_RES_THR: rdata_next = 32'(res_thr_reg[wgrp]);
          `CBF_GRP_RETRIP_DLY: rdata_next = 32'(rt_dly_reg[wgrp]);
          `CBF_GRP_FAIL_DLY: rdata_next = 32'(bf_dly_reg[wgrp]);
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_reg <= `CBF_CTRL_RESET;
      sig_mask_reg <= '0;
      relay_mask_reg <= '0;
      rdata_reg <= 32'h0000_0000;
      for (int g = 0; g < NUM_GROUPS; g++) begin
        phase_thr_reg[g] <= `CBF_PHASE_THR_RESET;
        res_thr_reg[g] <= `CBF_RES_THR_RESET;
        rt_dly_reg[g] <= `CBF_RETRIP_DLY_RESET;
        bf_dly_reg[g] <= `CBF_FAIL_DLY_RESET;
      end
    end else begin
      ctrl_reg <= ctrl_next;
      sig_mask_reg <= sig_mask_next;
      relay_mask_reg <= relay_mask_next;
      rdata_reg <= rdata_next;
      phase_thr_reg <= phase_thr_next;
      res_thr_reg <= res_thr_next;
      rt_dly_reg <= rt_dly_next;
      bf_dly_reg <= bf_dly_next;
    end
  end

  // choose residual among three fundamental magnitudes
  always_comb begin
    unique case (res_sel)
      CBF_RES_OFF: res_mag = 16'h0000;
      CBF_RES_ONE: res_mag = meas.residual_input_one;
      CBF_RES_TWO: res_mag = meas.residual_input_two;
      CBF_RES_CALC: res_mag = meas.calculated_residual;
    endcase
  end

  assign phase_mag[0] = meas.phase_a;
  assign phase_mag[1] = meas.phase_b;
  assign phase_mag[2] = meas.phase_c;

  // one element per phase, common threshold
  for (genvar p = 0; p < 3; p++) begin : g_phase
    cbf_pickup #(.W(16)) u_pick (
      .core_clk(core_clk),
      .srst(srst),
      .tick(tick_reg),
      .enable(use_cur),
      .magnitude(phase_mag[p]),
      .threshold(16'(phase_thr_reg[active_group])),
      .picked(cur_picked[p])
    );
  end

  cbf_pickup #(.W(16)) u_res_pick (
    .core_clk(core_clk),
    .srst(srst),
    .tick(tick_reg),
    .enable(use_cur && res_sel != CBF_RES_OFF),
    .magnitude(res_mag),
    .threshold(res_thr_reg[active_group]),
    .picked(cur_picked[3])
  );

  assign cur_pick = |cur_picked;
  assign sig_pick = use_sig && |(binary_signals & sig_mask_reg);
  assign relay_pick = use_relay && |(relay_states & relay_mask_reg);

  // combine enabled kinds by AND or OR
  always_comb begin
    if (!(use_cur || use_sig || use_relay)) begin
      pickup = 1'b0;
    end else if (and_mode) begin
      pickup = (cur_pick || !use_cur) && (sig_pick || !use_sig) &&
        (relay_pick || !use_relay);
    end else begin
      pickup = cur_pick || sig_pick || relay_pick;
    end
  end

  always_comb begin
    tick_next = 1'b0;
    div_next = div_reg + CW'(1);
    if (div_reg == CW'(CYCLE_CLKS - 1)) begin
      div_next = '0;
      tick_next = 1'b1;
    end
  end

  // Timers and condition, advanced once per program cycle
  always_comb begin
    rt_cnt_next = rt_cnt_reg;
    bf_cnt_next = bf_cnt_reg;
    cond_next = cond_reg;
    if (tick_reg) begin
      if (!pickup) begin
        rt_cnt_next = '0;
        bf_cnt_next = '0;
        cond_next = CBF_NORMAL;
      end else if (block_in) begin
        rt_cnt_next = '0;
        bf_cnt_next = '0;
        cond_next = CBF_BLOCKED;
      end else begin
        if (rt_cnt_reg < rt_dly_reg[active_group]) begin
          rt_cnt_next = rt_cnt_reg + DLY_W'(1);
        end
        if (bf_cnt_reg < bf_dly_reg[active_group]) begin
          bf_cnt_next = bf_cnt_reg + DLY_W'(1);
        end
        if (bf_cnt_next >= bf_dly_reg[active_group]) begin
          cond_next = CBF_FAIL;
        end else if (rt_cnt_next >= rt_dly_reg[active_group]) begin
          cond_next = CBF_RETRIP;
        end else begin
          cond_next = CBF_START;
        end
      end
    end
  end

  // Shown condition and outputs; forcing bypasses the timers
  always_comb begin
    shown_next = cond_next;
    if (stage_forcing_en && override_cond <= CBF_BLOCKED) begin
      shown_next = override_cond;
    end
    start_next = shown_next != CBF_NORMAL && shown_next != CBF_BLOCKED;
    blocked_next = shown_next == CBF_BLOCKED;
    fail_next = shown_next == CBF_FAIL;
    retrip_next = retrip_en && (shown_next == CBF_RETRIP || shown_next == CBF_FAIL);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
      rt_cnt_reg <= '0;
      bf_cnt_reg <= '0;
      cond_reg <= CBF_NORMAL;
      shown_reg <= CBF_NORMAL;
      start_reg <= 1'b0;
      blocked_reg <= 1'b0;
      retrip_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
      rt_cnt_reg <= rt_cnt_next;
      bf_cnt_reg <= bf_cnt_next;
      cond_reg <= cond_next;
      shown_reg <= shown_next;
      start_reg <= start_next;
      blocked_reg <= blocked_next;
      retrip_reg <= retrip_next;
      fail_reg <= fail_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign condition = shown_reg;
  assign start_out = start_reg;
  assign blocked_out = blocked_reg;
  assign redundant_trip_out = retrip_reg;
  assign breaker_failure_output = fail_reg;
endmodule // cbf_supervisor

// ### cbf_supervisor_chk.sv
/* Port checker of the breaker failure supervisor.
   Assumes it is bound to cbf_supervisor on one clock. */
`timescale 1ns/1ps
`include "cbf_defines.svh"
module cbf_supervisor_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [31:0] reg_rdata,
  input wire logic block_in,
  input wire logic stage_forcing_en,
  input wire logic start_out,
  input wire logic blocked_out,
  input wire logic redundant_trip_out,
  input wire logic breaker_failure_output,
  input wire cbf_pkg::cbf_cond_t condition
);
  import cbf_pkg::*;
  logic ren_reg, ren_next;
  logic [2:0] ovr_reg, ovr_next;
  logic ctrl_wr, unmapped;
  // Decode of control writes and holes in the map
  assign ctrl_wr = reg_we && reg_addr == `CBF_ADDR_CTRL;
  assign unmapped = reg_addr[5:2] == 4'h1 || reg_addr > 6'h17;
  // Shadow of retrip enable and override; reset leaves retrip on
  always_comb begin
    ren_next = ctrl_wr ? reg_wdata[`CBF_CTRL_RETRIP_EN] : ren_reg;
    ovr_next = ctrl_wr ? reg_wdata[10:8] : ovr_reg;
    if (srst) begin
      ren_next = 1'b1;
      ovr_next = 3'h0;
    end
  end
  // Registers only
  always_ff @(posedge core_clk) begin
    ren_reg <= ren_next;
    ovr_reg <= ovr_next;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_ctrl_wr_rd;
    ctrl_wr ##2 (reg_re && reg_addr == `CBF_ADDR_CTRL);
  endsequence
  sequence s_force_wr;
    (stage_forcing_en && ctrl_wr && reg_wdata[10:8] <= 3'h4) ##1 stage_forcing_en;
  endsequence
  property p_rst;
    $fell(srst) |-> condition == CBF_NORMAL && !breaker_failure_output && reg_rdata == 32'h0;
  endproperty
  property p_idle; !$past(reg_re) |-> reg_rdata == 32'h0; endproperty
  property p_hole; reg_re && unmapped |=> reg_rdata == 32'h0; endproperty
  property p_ctrl_rb; s_ctrl_wr_rd |=> reg_rdata == ($past(reg_wdata, 3) & 32'h0000077f); endproperty
  property p_fail; breaker_failure_output == (condition == CBF_FAIL); endproperty
  property p_start; start_out == (condition inside {CBF_START, CBF_RETRIP, CBF_FAIL}); endproperty
  property p_blk; blocked_out == (condition == CBF_BLOCKED); endproperty
  property p_retrip;
    redundant_trip_out |-> $past(ren_reg) && condition inside {CBF_RETRIP, CBF_FAIL};
  endproperty
  property p_force; s_force_wr |=> condition == ovr_reg; endproperty
  property p_blk_cause;
    $rose(blocked_out) && !$past(stage_forcing_en) && !$past(stage_forcing_en, 2) |-> $past(block_in);
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
  a_fail: assert property (p_fail) else $error("failure output mismatch");
  a_start: assert property (p_start) else $error("start output mismatch");
  a_blk: assert property (p_blk) else $error("blocked output mismatch");
  a_retrip: assert property (p_retrip) else $error("retrip output unexpected");
  a_force: assert property (p_force) else $error("override not shown");
  a_blk_cause: assert property (p_blk_cause) else $error("blocked without block");
endmodule // cbf_supervisor_chk

bind cbf_supervisor cbf_supervisor_chk i_chk (
  .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .block_in(block_in),
  .stage_forcing_en(stage_forcing_en), .start_out(start_out), .blocked_out(blocked_out),
  .redundant_trip_out(redundant_trip_out), .breaker_failure_output(breaker_failure_output),
  .condition(condition)
);

// ### cbf_breaker_model.sv
/* Breaker pair model: feeder breaker with optional second coil, and
   upstream breaker. Assumes the bench gates fault current by it. */
`timescale 1ns/1ps
module cbf_breaker_model (
  input wire logic core_clk,
  input wire logic reclose,
  input wire logic coil_ok,
  input wire logic redundant_trip_out,
  input wire logic breaker_failure_output,
  output logic fault_flows
);
  logic flows_reg, flows_next;
  // second coil opens only with coil_ok, upstream always opens
  always_comb begin
    flows_next = flows_reg;
    if (breaker_failure_output || (coil_ok && redundant_trip_out)) flows_next = 1'b0;
    if (reclose) flows_next = 1'b1;
  end
  // Registers only; opening takes one cycle
  always_ff @(posedge core_clk) flows_reg <= flows_next;
  assign fault_flows = flows_reg;
endmodule // cbf_breaker_model

// ### breaker_failure_supervision_bench.sv
/* Bench of the breaker failure supervisor, short program cycle.
   Assumes the breaker model and the bound port checker. */
`timescale 1ns/1ps
`include "cbf_defines.svh"
module breaker_failure_supervision_bench;
  import cbf_pkg::*;
  logic core_clk = 0, srst = 1, reg_we = 0, reg_re = 0, block_in = 0, stage_forcing_en = 0;
  logic reclose = 1, coil_ok = 0, fault_flows;
  logic [5:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [47:0] ph = 0, res = 0;
  logic [15:0] sigs = 0;
  logic [7:0] relays = 0;
  logic [1:0] active_group = 0;
  logic start_out, blocked_out, redundant_trip_out, breaker_failure_output;
  cbf_cond_t condition;
  int fail_count = 0, compares = 0, cycles = 0;
  // Open breakers carry no current
  cbf_meas_t meas;
  assign meas = fault_flows ? {ph, res} : '0;
  always #50 core_clk = ~core_clk;
  cbf_supervisor #(.CYCLE_CLKS(8)) i_dut (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .meas(meas),
    .binary_signals(sigs), .relay_states(relays), .active_group(active_group),
    .block_in(block_in), .stage_forcing_en(stage_forcing_en), .start_out(start_out),
    .blocked_out(blocked_out), .redundant_trip_out(redundant_trip_out),
    .breaker_failure_output(breaker_failure_output), .condition(condition)
  );
  cbf_breaker_model i_brk (
    .core_clk(core_clk), .reclose(reclose), .coil_ok(coil_ok), .redundant_trip_out(redundant_trip_out),
    .breaker_failure_output(breaker_failure_output), .fault_flows(fault_flows)
  );
  task automatic end_of_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // Bus cycles: strobe for one edge, then a quiet edge
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge core_clk);
    reg_we <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge core_clk);
    reg_re <= 1'b0;
    #1;
    chk("rdata", e, reg_rdata);
    @(posedge core_clk);
  endtask
  // Bounded wait for a shown condition
  task automatic wcond(input cbf_cond_t c, input int n);
    int i;
    i = 0;
    #1;
    while (condition !== c && i < n) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    chk("condition", c, condition);
  endtask
  // Condition after exactly n edges
  task automatic stay(input cbf_cond_t c, input int n);
    repeat (n) @(posedge core_clk);
    #1;
    chk("condition", c, condition);
  endtask
  task automatic reclose_brk;
    ph <= '0;
    reclose <= 1'b1;
    @(posedge core_clk);
    reclose <= 1'b0;
    @(posedge core_clk);
  endtask
  // Hang guard, far above the roughly seven hundred cycles needed
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    reclose <= 1'b0;
    @(posedge core_clk);
    rd(`CBF_ADDR_CTRL, 32'h11);
    rd(6'h08, 32'h14);
    rd(6'h09, 32'h4b0);
    rd(6'h0a, 32'h14);
    rd(6'h0b, 32'h28);
    rd(6'h05, 32'h0);
    wr(6'h0a, 32'h2);
    wr(6'h0b, 32'h4);
    wr(6'h0e, 32'h64);
    wr(6'h0f, 32'h64);
    wr(6'h10, 32'h32);
    // Dead second coil: retrip at two cycles, failure at four
    ph <= 48'h0000_0015_0000;
    wcond(CBF_START, 30);
    stay(CBF_START, 5);
    stay(CBF_RETRIP, 4);
    stay(CBF_RETRIP, 14);
    stay(CBF_FAIL, 2);
    wcond(CBF_NORMAL, 20);
    reclose_brk();
    coil_ok <= 1'b1;
    ph <= 48'h0000_0000_0015;
    wcond(CBF_RETRIP, 40);
    chk("retrip", 32'h1, redundant_trip_out);
    wcond(CBF_NORMAL, 20);
    reclose_brk();
    wr(`CBF_ADDR_CTRL, 32'h01);
    ph <= 48'h0015_0000_0000;
    wcond(CBF_FAIL, 50);
    chk("retrip", 32'h0, redundant_trip_out);
    wcond(CBF_NORMAL, 20);
    reclose_brk();
    wr(`CBF_ADDR_CTRL, 32'h11);
    // Group two has a higher threshold, group one long delays
    active_group <= 2'h2;
    ph <= 48'h001e_0000_0000;
    stay(CBF_NORMAL, 24);
    active_group <= 2'h1;
    wcond(CBF_START, 30);
    ph <= 48'h0014_0000_0000;
    stay(CBF_START, 24);
    ph <= 48'h0013_0000_0000;
    wcond(CBF_NORMAL, 20);
    for (int p = 0; p < 3; p++) begin
      ph <= 48'h15 << (16 * p);
      wcond(CBF_START, 30);
      ph <= '0;
      wcond(CBF_NORMAL, 20);
    end
    res <= {3{16'h04b1}};
    stay(CBF_NORMAL, 24);
    for (int s = 1; s < 4; s++) begin
      wr(`CBF_ADDR_CTRL, 32'h11 | (s << 5));
      res <= 48'h04b1 << (16 * ((4 - s) % 3));
      stay(CBF_NORMAL, 24);
      res <= 48'h04b1 << (16 * (3 - s));
      wcond(CBF_START, 30);
      res <= '0;
      wcond(CBF_NORMAL, 20);
    end
    // Masks survive the group switch; other kinds ignored
    wr(`CBF_ADDR_SIG_MASK, 32'h4);
    wr(`CBF_ADDR_RELAY_MASK, 32'h1);
    wr(`CBF_ADDR_CTRL, 32'h14);
    active_group <= 2'h3;
    sigs <= 16'h000b;
    relays <= 8'hff;
    ph <= 48'h15 << 32;
    stay(CBF_NORMAL, 24);
    rd(`CBF_ADDR_SIG_MASK, 32'h4);
    sigs <= 16'h0004;
    wcond(CBF_START, 30);
    sigs <= '0;
    wcond(CBF_NORMAL, 20);
    wr(`CBF_ADDR_CTRL, 32'h12);
    wcond(CBF_START, 30);
    relays <= 8'hfe;
    wcond(CBF_NORMAL, 20);
    ph <= '0;
    relays <= 8'h01;
    wr(`CBF_ADDR_CTRL, 32'h1b);
    stay(CBF_NORMAL, 24);
    ph <= 48'h15 << 32;
    wcond(CBF_START, 30);
    block_in <= 1'b1;
    wcond(CBF_BLOCKED, 20);
    rd(`CBF_ADDR_STATUS, 32'h78);
    block_in <= 1'b0;
    wcond(CBF_START, 30);
    ph <= '0;
    wr(`CBF_ADDR_CTRL, 32'h311);
    stay(CBF_NORMAL, 24);
    stage_forcing_en <= 1'b1;
    for (int v = 0; v < 5; v++) begin
      wr(`CBF_ADDR_CTRL, 32'h11 | (v << 8));
      rd(`CBF_ADDR_CTRL, 32'h11 | (v << 8));
      #1;
      chk("forced", v, condition);
    end
    end_of_test();
  end
endmodule // breaker_failure_supervision_bench
